// ### logic/clsr_dev.sv
// Colour sensor end: serial slave with its register file.
//
// Implementation choice: the two-wire serial interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module clsr_dev
  import clsr_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a  // Arbitrary value.
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  clsr_if.dev bus,
  input wire logic res_valid_i,
  input wire logic [15:0] green_i,
  input wire logic [15:0] red_i,
  input wire logic [15:0] blue_i,
  input wire logic done_i,
  input wire logic alarm_i,
  output logic [2:0] mode_o,
  output logic range_select_o,
  output logic [2:0] chan_en_o,
  output logic converting_o,
  output logic alarm_n_o
);
  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_RX = 6'h02,
    D_ACK = 6'h04,
    D_TX = 6'h08,
    D_MACK = 6'h10,
    D_COMMIT = 6'h20
  } clsr_dst_e;

  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  clsr_dst_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [1:0] bnum_r, bnum_nxt;
  logic rw_r, rw_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic adv_r, adv_nxt;
  logic mack_r, mack_nxt;
  logic oe_r, oe_nxt;
  logic [3:0] ccnt_r, ccnt_nxt;
  logic [7:0] pend_r [0:14];
  logic [7:0] pend_nxt [0:14];
  logic [14:0] pmask_r, pmask_nxt;
  logic [7:0] regs_r [0:14];
  logic [7:0] regs_nxt [0:14];
  logic [2:0] chan_r, chan_nxt;
  logic [3:0] tgt;
  logic [7:0] rd_cur;
  logic rd_done;
  logic commit;

  // Line samples pass two flops; the edge detectors compare the second with a third flop holding its previous value.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      scl_d_r <= scl_sy_r[1];
      sda_d_r <= sda_sy_r[1];
    end
  end

  assign scl_s = scl_sy_r[1];
  assign sda_s = sda_sy_r[1];
  assign rise = scl_s & ~scl_d_r;
  assign fall = ~scl_s & scl_d_r;
  assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign tgt = adv_r ? next_index(ptr_r) : ptr_r;
  assign rd_cur = (ptr_r == IDX_ID) ? PART_ID : regs_r[ptr_r];

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    bnum_nxt = bnum_r;
    rw_nxt = rw_r;
    ptr_nxt = ptr_r;
    adv_nxt = adv_r;
    mack_nxt = mack_r;
    oe_nxt = oe_r;
    ccnt_nxt = ccnt_r;
    pend_nxt = pend_r;
    pmask_nxt = pmask_r;
    rd_done = 1'b0;
    commit = 1'b0;
    if (st_r == D_COMMIT)
    begin
      // The bus is not watched for COMMIT_CYC cycles after the staged bytes land.
      oe_nxt = 1'b0;
      if (ccnt_r == 4'(COMMIT_CYC - 1))
        st_nxt = D_IDLE;
      else
        ccnt_nxt = ccnt_r + 4'h1;
    end
    else if (stop_c)
    begin
      // Only fully acknowledged data bytes were staged, so an early stop drops nothing else.
      oe_nxt = 1'b0;
      ccnt_nxt = 4'h0;
      commit = |pmask_r;
      st_nxt = commit ? D_COMMIT : D_IDLE;
    end
    else if (start_c)
    begin
      oe_nxt = 1'b0;
      cnt_nxt = 4'h0;
      bnum_nxt = 2'h0;
      st_nxt = D_RX;
    end
    else
    begin
      case (st_r)
        D_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        D_RX:
        begin
          if (rise)
          begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (fall && cnt_r == 4'h8)
          begin
            oe_nxt = 1'b1;
            st_nxt = D_ACK;
            if (bnum_r == 2'h0)
            begin
              rw_nxt = sh_r[0];
              if (sh_r[7:1] != DEV_ADDR)
              begin
                oe_nxt = 1'b0;
                st_nxt = D_IDLE;
              end
            end
            else if (bnum_r == 2'h1)
            begin
              ptr_nxt = (sh_r > {4'h0, IDX_LAST}) ? IDX_ID : sh_r[3:0];
              adv_nxt = 1'b0;
            end
            else
            begin
              ptr_nxt = tgt;
              adv_nxt = 1'b1;
              pend_nxt[tgt] = sh_r;
              pmask_nxt[tgt] = 1'b1;
            end
          end
        end
        D_ACK:
        begin
          if (fall)
          begin
            cnt_nxt = 4'h0;
            bnum_nxt = (bnum_r == 2'h2) ? bnum_r : bnum_r + 2'h1;
            if (bnum_r == 2'h0 && rw_r)
            begin
              sh_nxt = rd_cur;
              oe_nxt = ~rd_cur[7];
              st_nxt = D_TX;
            end
            else
            begin
              oe_nxt = 1'b0;
              st_nxt = D_RX;
            end
          end
        end
        D_TX:
        begin
          if (fall)
          begin
            if (cnt_r == 4'h7)
            begin
              oe_nxt = 1'b0;
              rd_done = 1'b1;
              ptr_nxt = next_index(ptr_r);
              st_nxt = D_MACK;
            end
            else
            begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        D_MACK:
        begin
          if (rise)
            mack_nxt = ~sda_s;
          else if (fall)
          begin
            cnt_nxt = 4'h0;
            if (mack_r)
            begin
              sh_nxt = rd_cur;
              oe_nxt = ~rd_cur[7];
              st_nxt = D_TX;
            end
            else
              st_nxt = D_IDLE;
          end
        end
        default:
        begin
          oe_nxt = 1'b0;
          st_nxt = D_IDLE;
        end
      endcase
    end
    if (commit)
      pmask_nxt = '0;
  end

  always_comb
  begin
    regs_nxt = regs_r;
    regs_nxt[IDX_ID] = RST_ZERO;
    if (res_valid_i)
    begin
      regs_nxt[IDX_GRN_L] = green_i[7:0];
      regs_nxt[IDX_GRN_H] = green_i[15:8];
      regs_nxt[IDX_RED_L] = red_i[7:0];
      regs_nxt[IDX_RED_H] = red_i[15:8];
      regs_nxt[IDX_BLU_L] = blue_i[7:0];
      regs_nxt[IDX_LAST] = blue_i[15:8];
    end
    if (done_i)
      regs_nxt[IDX_STAT][CONV_DONE_BIT] = 1'b1;
    if (rd_done && ptr_r == IDX_STAT)
      regs_nxt[IDX_STAT][WIN_ALARM_BIT] = 1'b0;
    if (alarm_i)
      regs_nxt[IDX_STAT][WIN_ALARM_BIT] = 1'b1;
    if (commit)
    begin
      if (pmask_r[0] && pend_r[0] == SOFT_RESET_CODE)
      begin
        for (int i = 0; i < 15; i++)
          regs_nxt[i] = reg_default(4'(i));
      end
      else
      begin
        // Writes to the identity and status locations are dropped here.
        for (int i = 1; i < 15; i++)
          if (pmask_r[i] && 4'(i) != IDX_STAT)
            regs_nxt[i] = pend_r[i];
      end
    end
    chan_nxt = mode_channels(regs_nxt[IDX_CFG1][2:0]);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= D_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      bnum_r <= 2'h0;
      rw_r <= 1'b0;
      ptr_r <= IDX_ID;
      adv_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      ccnt_r <= 4'h0;
      pmask_r <= '0;
      chan_r <= 3'h0;
      for (int i = 0; i < 15; i++)
      begin
        pend_r[i] <= RST_ZERO;
        regs_r[i] <= reg_default(4'(i));
      end
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      bnum_r <= bnum_nxt;
      rw_r <= rw_nxt;
      ptr_r <= ptr_nxt;
      adv_r <= adv_nxt;
      mack_r <= mack_nxt;
      oe_r <= oe_nxt;
      ccnt_r <= ccnt_nxt;
      pmask_r <= pmask_nxt;
      chan_r <= chan_nxt;
      pend_r <= pend_nxt;
      regs_r <= regs_nxt;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_r;
  assign mode_o = regs_r[IDX_CFG1][2:0];
  assign range_select_o = regs_r[IDX_CFG1][RANGE_BIT];
  assign chan_en_o = chan_r;
  // Converter keeps running for as long as any channel is enabled.
  assign converting_o = |chan_r;
  assign alarm_n_o = ~regs_r[IDX_STAT][WIN_ALARM_BIT];
endmodule
`default_nettype wire

// ### logic/clsr_host.sv
// Bus master end: AHB-Lite command registers driving single-byte register accesses.
`timescale 1ns/10ps
`default_nettype none
module clsr_host
  import clsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  clsr_if.host bus,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o
);
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_START = 5'h02,
    H_TX = 5'h04,
    H_RX = 5'h08,
    H_STOP = 5'h10
  } clsr_hst_e;

  logic [1:0] sda_sy_r;
  clsr_hst_e st_r, st_nxt;
  logic [2:0] seq_r, seq_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] b_r, b_nxt;
  logic [7:0] dv_r, dv_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic scl_oe_r, scl_oe_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic nack_r, nack_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic ap;
  logic tick;
  logic sda_s;

  function automatic clsr_hst_e step_state(logic [2:0] s, logic rd);
    if (s == 3'h0 || (rd && s == 3'h3))
      return H_START;
    if ((!rd && s == 3'h4) || s == 3'h6)
      return H_STOP;
    if (rd && s == 3'h5)
      return H_RX;
    return H_TX;
  endfunction

  function automatic logic [7:0] step_byte(logic [2:0] s, logic rd, logic [7:0] idx, logic [7:0] dat);
    if (s == 3'h1)
      return {DEV_ADDR, 1'b0};
    if (s == 3'h2)
      return idx;
    if (rd && s == 3'h4)
      return {DEV_ADDR, 1'b1};
    return dat;
  endfunction

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sda_sy_r <= 2'h3;
    else
      sda_sy_r <= {sda_sy_r[0], bus.sda};
  end

  assign sda_s = sda_sy_r[1];
  assign ap = hsel_i & htrans_i[1] & hready_i;
  assign tick = (dv_r == 8'h00);

  always_comb
  begin
    st_nxt = st_r;
    seq_nxt = seq_r;
    q_nxt = q_r;
    b_nxt = b_r;
    dv_nxt = dv_r;
    sh_nxt = sh_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    nack_nxt = nack_r;
    rdata_nxt = rdata_r;
    idx_nxt = idx_r;
    dat_nxt = dat_r;
    rd_nxt = rd_r;
    wr_nxt = ap & hwrite_i;
    wa_nxt = ap ? haddr_i[7:0] : wa_r;
    hrdata_nxt = hrdata_r;
    if (ap && !hwrite_i)
    begin
      // Read data is fetched in the address phase so it stands from a flop in the data phase.
      if (haddr_i[7:0] == CMD_OFS)
        hrdata_nxt = {15'h0000, rd_r, dat_r, idx_r};
      else if (haddr_i[7:0] == STAT_OFS)
        hrdata_nxt = {16'h0000, rdata_r, 6'h00, nack_r, st_r != H_IDLE};
      else
        hrdata_nxt = 32'h0000_0000;
    end
    if (st_r == H_IDLE)
    begin
      scl_oe_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
      // A command written while a transfer runs is dropped.
      if (wr_r && wa_r == CMD_OFS)
      begin
        idx_nxt = hwdata_i[7:0];
        dat_nxt = hwdata_i[15:8];
        rd_nxt = hwdata_i[CMD_RD_BIT];
        nack_nxt = 1'b0;
        seq_nxt = 3'h0;
        q_nxt = 2'h0;
        dv_nxt = 8'(QTR_CYC - 1);
        st_nxt = H_START;
      end
    end
    else
    begin
      dv_nxt = tick ? 8'(QTR_CYC - 1) : dv_r - 8'h01;
      if (tick)
      begin
        q_nxt = q_r + 2'h1;
        case (st_r)
          H_START:
          begin
            // Also serves as repeated start: SCL is low on entry.
            case (q_r)
              2'h0: sda_oe_nxt = 1'b0;
              2'h1: scl_oe_nxt = 1'b0;
              2'h2: sda_oe_nxt = 1'b1;
              default:
              begin
                scl_oe_nxt = 1'b1;
                seq_nxt = seq_r + 3'h1;
                st_nxt = step_state(seq_r + 3'h1, rd_r);
                sh_nxt = step_byte(seq_r + 3'h1, rd_r, idx_r, dat_r);
                b_nxt = 4'h0;
              end
            endcase
          end
          H_STOP:
          begin
            case (q_r)
              2'h0: sda_oe_nxt = 1'b1;
              2'h1: scl_oe_nxt = 1'b0;
              2'h2: sda_oe_nxt = 1'b0;
              default: st_nxt = H_IDLE;
            endcase
          end
          H_TX, H_RX:
          begin
            case (q_r)
              2'h0: sda_oe_nxt = (st_r == H_TX && b_r != 4'h8) ? ~sh_r[7] : 1'b0;
              2'h1: scl_oe_nxt = 1'b0;
              2'h2:
              begin
                if (st_r == H_TX && b_r == 4'h8)
                  nack_nxt = nack_r | sda_s;
                else if (st_r == H_RX && b_r != 4'h8)
                  sh_nxt = {sh_r[6:0], sda_s};
              end
              default:
              begin
                scl_oe_nxt = 1'b1;
                b_nxt = b_r + 4'h1;
                if (st_r == H_TX)
                  sh_nxt = {sh_r[6:0], 1'b0};
                if (b_r == 4'h8)
                begin
                  if (st_r == H_RX)
                    rdata_nxt = sh_r;
                  if (nack_r)
                  begin
                    seq_nxt = rd_r ? 3'h6 : 3'h4;
                    st_nxt = H_STOP;
                  end
                  else
                  begin
                    seq_nxt = seq_r + 3'h1;
                    st_nxt = step_state(seq_r + 3'h1, rd_r);
                    sh_nxt = step_byte(seq_r + 3'h1, rd_r, idx_r, dat_r);
                    b_nxt = 4'h0;
                  end
                end
              end
            endcase
          end
          default: st_nxt = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= H_IDLE;
      seq_r <= 3'h0;
      q_r <= 2'h0;
      b_r <= 4'h0;
      dv_r <= 8'h00;
      sh_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      nack_r <= 1'b0;
      rdata_r <= 8'h00;
      idx_r <= 8'h00;
      dat_r <= 8'h00;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
      seq_r <= seq_nxt;
      q_r <= q_nxt;
      b_r <= b_nxt;
      dv_r <= dv_nxt;
      sh_r <= sh_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      nack_r <= nack_nxt;
      rdata_r <= rdata_nxt;
      idx_r <= idx_nxt;
      dat_r <= dat_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      wa_r <= wa_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_r;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
endmodule
`default_nettype wire

// ### logic/clsr_if.sv
// Two-wire link between the bus master and the colour sensor.
`timescale 1ns/10ps
`default_nettype none
interface clsr_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: any enabled low driver wins.
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (output scl_o, output scl_oe, output host_sda_o, output host_sda_oe, input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// ### logic/clsr_pkg.sv
// Shared constants, register map and helpers for the colour sensor serial link.
`default_nettype none
package clsr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h44;
  localparam logic [3:0] IDX_ID = 4'h0;
  localparam logic [3:0] IDX_CFG1 = 4'h1;
  localparam logic [3:0] IDX_LO_BND_H = 4'h5;
  localparam logic [3:0] IDX_HI_BND_L = 4'h6;
  localparam logic [3:0] IDX_HI_BND_H = 4'h7;
  localparam logic [3:0] IDX_STAT = 4'h8;
  localparam logic [3:0] IDX_GRN_L = 4'h9;
  localparam logic [3:0] IDX_GRN_H = 4'ha;
  localparam logic [3:0] IDX_RED_L = 4'hb;
  localparam logic [3:0] IDX_RED_H = 4'hc;
  localparam logic [3:0] IDX_BLU_L = 4'hd;
  localparam logic [3:0] IDX_LAST = 4'he;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h46;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BOUND_HI = 8'hff;
  localparam logic [7:0] RST_STATUS = 8'h04;
  localparam int RANGE_BIT = 3;
  localparam int WIN_ALARM_BIT = 0;
  localparam int CONV_DONE_BIT = 1;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_G = 3'h1;
  localparam logic [2:0] MODE_R = 3'h2;
  localparam logic [2:0] MODE_B = 3'h3;
  localparam logic [2:0] MODE_STBY = 3'h4;
  localparam logic [2:0] MODE_GRB = 3'h5;
  localparam logic [2:0] MODE_GR = 3'h6;
  localparam logic [2:0] MODE_GB = 3'h7;
  localparam int COMMIT_CYC = 8;
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CMD_RD_BIT = 16;
  localparam int STAT_NACK_BIT = 1;

  function automatic logic [7:0] reg_default(logic [3:0] idx);
    if (idx == IDX_HI_BND_L || idx == IDX_HI_BND_H)
      return RST_BOUND_HI;
    if (idx == IDX_STAT)
      return RST_STATUS;
    return RST_ZERO;
  endfunction

  function automatic logic [3:0] next_index(logic [3:0] idx);
    return (idx == IDX_LAST) ? IDX_ID : idx + 4'h1;
  endfunction

  // Returns the enabled channels as {blue, red, green}.
  function automatic logic [2:0] mode_channels(logic [2:0] m);
    case (m)
      MODE_G: return 3'h1;
      MODE_R: return 3'h2;
      MODE_B: return 3'h4;
      MODE_GRB: return 3'h7;
      MODE_GR: return 3'h3;
      MODE_GB: return 3'h5;
      default: return 3'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### testbench/clsr_monitor.sv
// Checker watching the two-wire link between the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
module clsr_monitor
  import clsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r;
  logic sda_r;
  logic first_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic start_w;
  logic stop_w;
  logic rise_w;
  assign start_w = scl && scl_r && sda_r && !sda;
  assign stop_w = scl && scl_r && !sda_r && sda;
  assign rise_w = scl && !scl_r;
  // The bit count restarts at every START, so a repeated START frames a new address byte.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      first_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      if (start_w || stop_w)
      begin
        first_r <= start_w;
        cnt_r <= 4'h0;
      end
      else if (rise_w)
      begin
        cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
        if (cnt_r < 4'h8)
          sh_r <= {sh_r[6:0], sda};
        if (cnt_r == 4'h8)
          first_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_stop_quiet: assert property (stop_w |-> !dev_sda_oe [*8])
    else $error("device drove data right after stop");
  a_start_host: assert property (start_w |-> host_sda_oe)
    else $error("start not made by host");
  a_stop_host: assert property (stop_w |-> $past(host_sda_oe))
    else $error("stop not made by host");
  a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> scl_oe && !scl)
    else $error("device changed data while clock high");
  a_addr_quiet: assert property (rise_w && first_r && cnt_r < 4'h8 |-> !dev_sda_oe)
    else $error("device drove during address byte");
  a_addr_ack: assert property (rise_w && first_r && cnt_r == 4'h8 |-> sda == (sh_r[7:1] != DEV_ADDR))
    else $error("address acknowledge wrong");
  a_ack_stands: assert property (rise_w |-> $stable(dev_sda_oe) [*8])
    else $error("device data not held");
  a_scl_high: assert property (rise_w |-> scl [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the host and device ends of the colour sensor link.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import clsr_pkg::*;
;
  localparam logic [7:0] PID = 8'h3c; // Arbitrary value.
  localparam logic [2:0] CHN [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h7, 3'h3, 3'h5};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hrdy;
  logic [31:0] hrdata;
  logic hresp;
  logic rv = 1'b0;
  logic dn = 1'b0;
  logic al = 1'b0;
  logic [15:0] g = 16'h0;
  logic [15:0] r = 16'h0;
  logic [15:0] b = 16'h0;
  logic [2:0] bmode;
  logic brs;
  logic [2:0] bce;
  logic bcv;
  logic ban;
  logic [7:0] rq [16];
  int err_count = 0;
  int samples_checked = 0;
  clsr_if bus_a();
  clsr_if bus_b();
  clsr_host i_clsr_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_a), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata));
  clsr_dev #(.PART_ID(PID)) i_clsr_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_a), .res_valid_i(rv),
    .green_i(g), .red_i(r), .blue_i(b), .done_i(dn), .alarm_i(al), .mode_o(), .range_select_o(),
    .chan_en_o(), .converting_o(), .alarm_n_o());
  // Second device faces the bench directly, so faulty and fast framing can be tried cheaply.
  clsr_dev #(.PART_ID(PID)) i_clsr_dev_b (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_b), .res_valid_i(rv),
    .green_i(g), .red_i(r), .blue_i(b), .done_i(dn), .alarm_i(al), .mode_o(bmode), .range_select_o(brs),
    .chan_en_o(bce), .converting_o(bcv), .alarm_n_o(ban));
  clsr_monitor i_clsr_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_oe(bus_a.scl_oe),
    .host_sda_oe(bus_a.host_sda_oe), .dev_sda_oe(bus_a.dev_sda_oe), .scl(bus_a.scl), .sda(bus_a.sda));
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hwait();
    int n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (hrdy !== 1'b1 && n < 64);
    if (hrdy !== 1'b1)
    begin
      err_count++;
      test_done();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask
  // Busy is polled through the status word; an access can take tens of thousands of cycles.
  task automatic hop(input logic rd, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] st);
    int n = 0;
    ahb(1'b1, 32'h0, {15'h0, rd, d, idx}, st);
    do
    begin
      ahb(1'b0, 32'h4, 32'h0, st);
      n++;
    end
    while (st[0] !== 1'b0 && n < 40000);
    if (st[0] !== 1'b0)
    begin
      err_count++;
      test_done();
    end
  endtask
  task automatic bq();
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic bbit(input logic v, output logic s);
    bus_b.host_sda_oe <= !v;
    bq();
    bus_b.scl_oe <= 1'b0;
    bq();
    s = bus_b.sda;
    bq();
    bus_b.scl_oe <= 1'b1;
    bq();
  endtask
  task automatic bstart();
    bus_b.host_sda_oe <= 1'b0;
    bq();
    bus_b.scl_oe <= 1'b0;
    bq();
    bus_b.host_sda_oe <= 1'b1;
    bq();
    bus_b.scl_oe <= 1'b1;
    bq();
  endtask
  task automatic bstop();
    bus_b.host_sda_oe <= 1'b1;
    bq();
    bus_b.scl_oe <= 1'b0;
    bq();
    bus_b.host_sda_oe <= 1'b0;
    repeat (3) bq();
  endtask
  task automatic bbyte(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bbit(d[i], q[i]);
    bbit(ma, ak);
  endtask
  task automatic bwr(input logic [7:0] idx, input logic [7:0] d [4], input int n);
    logic [7:0] q;
    logic ak;
    bstart();
    bbyte(8'h88, 1'b1, q, ak);
    chk(32'(ak), 32'h0);
    bbyte(idx, 1'b1, q, ak);
    chk(32'(ak), 32'h0);
    for (int i = 0; i < n; i++)
    begin
      bbyte(d[i], 1'b1, q, ak);
      chk(32'(ak), 32'h0);
    end
    bstop();
  endtask
  task automatic brd(input logic setidx, input logic [7:0] idx, input int n);
    logic [7:0] q;
    logic ak;
    bstart();
    if (setidx)
    begin
      bbyte(8'h88, 1'b1, q, ak);
      bbyte(idx, 1'b1, q, ak);
      bstart();
    end
    bbyte(8'h89, 1'b1, q, ak);
    chk(32'(ak), 32'h0);
    for (int i = 0; i < n; i++)
      bbyte(8'hff, 1'(i == n - 1), rq[i], ak);
    bstop();
  endtask
  task automatic t_def();
    chk(32'(bmode), 32'h0);
    brd(1'b1, 8'h01, 15);
    for (int i = 0; i < 14; i++)
      chk(32'(rq[i]), (i == 5 || i == 6) ? 32'hff : (i == 7) ? 32'h4 : 32'h0);
    chk(32'(rq[14]), 32'(PID));
  endtask
  task automatic t_burst();
    bwr(8'h0d, '{8'h11, 8'h22, 8'h00, 8'h0d}, 4);
    brd(1'b0, 8'h00, 1);
    chk(32'(rq[0]), 32'h0d);
    brd(1'b1, 8'h0d, 2);
    chk(32'({rq[1], rq[0]}), 32'h2211);
    chk(32'({bmode, brs, bce, bcv}), {24'h0, 3'h5, 1'b1, 3'h7, 1'b1});
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++)
    begin
      bwr(8'h01, '{8'(m), 8'h0, 8'h0, 8'h0}, 1);
      chk(32'(bce), 32'(CHN[m]));
      chk(32'(bcv), 32'(CHN[m] != 3'h0));
    end
  endtask
  task automatic t_fault();
    logic [7:0] q;
    logic ak;
    bstart();
    bbyte(8'h88, 1'b1, q, ak);
    bbyte(8'h02, 1'b1, q, ak);
    for (int i = 0; i < 4; i++)
      bbit(1'b1, ak);
    bstop();
    brd(1'b1, 8'h02, 1);
    chk(32'(rq[0]), 32'h0);
    bstart();
    bbyte(8'h8a, 1'b1, q, ak);
    chk(32'(ak), 32'h1);
    bstop();
  endtask
  task automatic t_status();
    g <= 16'h1234;
    r <= 16'h5678;
    b <= 16'h9abc;
    rv <= 1'b1;
    dn <= 1'b1;
    al <= 1'b1;
    @(posedge sys_clk_i);
    rv <= 1'b0;
    dn <= 1'b0;
    al <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk(32'(ban), 32'h0);
    brd(1'b1, 8'h08, 7);
    chk({rq[0], rq[2], rq[1], rq[4]}, 32'h0712_3456);
    chk(32'({rq[3], rq[6], rq[5]}), 32'h0078_9abc);
    chk(32'(ban), 32'h1);
    brd(1'b1, 8'h08, 1);
    chk(32'(rq[0]), 32'h6);
  endtask
  task automatic t_reset();
    bwr(8'h00, '{SOFT_RESET_CODE, 8'h0, 8'h0, 8'h0}, 1);
    chk(32'(bmode), 32'h0);
    brd(1'b1, 8'h0d, 1);
    chk(32'(rq[0]), 32'h0);
    brd(1'b1, 8'h06, 1);
    chk(32'(rq[0]), 32'hff);
  endtask
  task automatic t_host();
    logic [31:0] st;
    hop(1'b0, 8'h04, 8'ha5, st);
    chk(32'(st[1]), 32'h0);
    hop(1'b1, 8'h04, 8'h00, st);
    chk(32'(st[15:8]), 32'ha5);
    ahb(1'b0, 32'h0, 32'h0, st);
    chk(st, 32'h0001_0004);
    ahb(1'b0, 32'h10, 32'h0, st);
    chk(st, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask
  initial
  begin
    bus_b.scl_o <= 1'b0;
    bus_b.host_sda_o <= 1'b0;
    bus_b.scl_oe <= 1'b0;
    bus_b.host_sda_oe <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_def();
    t_burst();
    t_modes();
    t_fault();
    t_status();
    t_reset();
    t_host();
    test_done();
  end
  initial
  begin
    repeat (150000) @(posedge sys_clk_i);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
